// ---- byte_op_asserts.sv ----
/* Port checker of the decoder.
   Assumes a bind onto every decoder instance. */
`timescale 1ns/1ns
`default_nettype none
module byte_op_asserts (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [15:0] instrWord,
  input wire byte_op_pkg::decode_s decodeOut,
  input wire logic s_axi_bvalid
);
  // ======================================================================
  // Properties.
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  byte_op_pkg::decode_s d;
  logic [4:0] o;
  assign d = decodeOut;
  assign o = decodeOut.op;
  chk_dest_route: assert property (d.valid && o == 5'h01 |->
    d.writeFile == $past(instrWord[9]) && d.writeWork == !d.writeFile) else $error("route");
  chk_file_low: assert property (d.valid && o == 5'h01 |->
    d.fileAddr[7:0] == $past(instrWord[7:0])) else $error("address");
  chk_arith_flags: assert property (d.valid && o inside {5'h01, 5'h02, [5'h0e:5'h10]}
    |-> d.flagMask == 5'h1f) else $error("arith flags");
  chk_logic_flags: assert property (d.valid && o inside {[5'h03:5'h06]}
    |-> d.flagMask == 5'h14) else $error("logic flags");
  chk_rot_flags: assert property (d.valid && o inside {[5'h11:5'h14]} |->
    d.flagMask == (o < 5'h13 ? 5'h15 : 5'h14)) else $error("rotate flags");
  chk_skip_quiet: assert property (d.valid && o inside {[5'h07:5'h0d]}
    |-> d.flagMask == 5'h00) else $error("skip flags");
  chk_mul_quiet: assert property (d.valid && o == 5'h15
    |-> d.flagMask == 5'h00 && d.cycles == 2'h1) else $error("multiply");
  chk_bra_offset: assert property (d.valid && o == 5'h1b |->
    d.branchOffset == $past(instrWord[10:0]) && d.cycles == 2'h2) else $error("branch");
  cover property (d.valid && o == 5'h16);
  cover property (d.valid && d.skip);
  cover property (s_axi_bvalid);
endmodule
bind byte_op_instruction_decoder byte_op_asserts byte_op_asserts_inst (.*);
`default_nettype wire

// ---- byte_op_instruction_decoder.sv ----
/*
  Decoder for the 16-bit program words of the core, with an AXI4-Lite register slave.
  Assumes fetch presents one word per instrValid and the next program word beside it,
  and that the data register file supplies operands and port/timer address hits.
*/
`timescale 1ns/1ns
`default_nettype none

module byte_op_instruction_decoder (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic instrValid,
  input wire logic [15:0] instrWord,
  input wire logic [15:0] nextWord,
  input wire logic [7:0] workingRegister,
  input wire logic [7:0] fileValue,
  input wire logic [7:0] pinLevels,
  input wire logic fileIsPort,
  input wire logic fileIsTimerZero,
  input wire logic [4:0] statusIn,
  output var byte_op_pkg::decode_s decodeOut,
  output logic [7:0] productHighByte,
  output logic [7:0] productLowByte,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ========================================================================
  // Two-word detection.
  function automatic logic isTwoWord(input logic [15:0] w);
    isTwoWord = (w[15:12] == `BOP_PREFIX_MOVE_FF) ||
                (w[15:8] == 8'he1 << 0 && 1'b0) ||
                (w[15:9] == 7'h76) || (w[15:8] == 8'hef) || (w[15:8] == 8'hee);
  endfunction

  // ========================================================================
  // State.
  byte_op_pkg::seq_e seq_q, seq_d;
  byte_op_pkg::decode_s dec_q, dec_d;
  logic [15:0] firstWord_q;
  logic [7:0] prodHigh_q, prodLow_q;
  logic [3:0] bank_q;
  logic prescaleAssigned_q;
  logic badSecond_q;

  // ========================================================================
  // Field extraction.
  wire logic [3:0] prefix = instrWord[15:12];
  wire logic [1:0] sub2 = instrWord[11:10];
  wire logic [2:0] sub3 = instrWord[11:9];
  wire logic destBit = instrWord[9];
  wire logic [7:0] fileLow = instrWord[7:0];
  wire logic [3:0] accessBank = (fileLow < `BOP_ACCESS_SPLIT) ? `BOP_ACCESS_LOW_BANK
                                                              : `BOP_ACCESS_HIGH_BANK;
  wire logic [11:0] effAddr = (instrWord[8] == `BOP_ACCESS_FORCED) ? {accessBank, fileLow}
                                                                   : {bank_q, fileLow};
  wire logic inSecond = (seq_q == byte_op_pkg::ST_SECOND);

  // ========================================================================
  // Opcode decode.
  byte_op_pkg::op_e op;
  always_comb begin
    op = byte_op_pkg::OP_CONTROL;
    unique case (prefix)
      4'h0: begin
        if (instrWord[11]) begin
          op = byte_op_pkg::OP_LITERAL;
        end else if (sub3 == 3'h1) begin
          op = byte_op_pkg::OP_MUL;
        end else if (sub2 == 2'h1) begin
          op = byte_op_pkg::OP_BYTE_OTHER;
        end
      end
      4'h1: begin
        unique case (sub2)
          2'h1: op = byte_op_pkg::OP_AND;
          2'h0: op = byte_op_pkg::OP_IOR;
          2'h2: op = byte_op_pkg::OP_XOR;
          2'h3: op = byte_op_pkg::OP_COM;
        endcase
      end
      4'h2: begin
        unique case (sub2)
          2'h1: op = byte_op_pkg::OP_ADD;
          2'h0: op = byte_op_pkg::OP_ADDC;
          2'h3: op = byte_op_pkg::OP_DECSZ;
          2'h2: op = byte_op_pkg::OP_BYTE_OTHER;
        endcase
      end
      4'h3: begin
        unique case (sub2)
          2'h1: op = byte_op_pkg::OP_RLC;
          2'h0: op = byte_op_pkg::OP_RRC;
          2'h3: op = byte_op_pkg::OP_INCSZ;
          2'h2: op = byte_op_pkg::OP_BYTE_OTHER;
        endcase
      end
      4'h4: begin
        unique case (sub2)
          2'h3: op = byte_op_pkg::OP_DECSNZ;
          2'h2: op = byte_op_pkg::OP_INCSNZ;
          2'h1: op = byte_op_pkg::OP_RLN;
          2'h0: op = byte_op_pkg::OP_RRN;
        endcase
      end
      4'h5: begin
        unique case (sub2)
          2'h3: op = byte_op_pkg::OP_SUB;
          2'h2: op = byte_op_pkg::OP_SUBB;
          2'h1: op = byte_op_pkg::OP_SUBFB;
          2'h0: op = byte_op_pkg::OP_BYTE_OTHER;
        endcase
      end
      4'h6: begin
        if (sub3 == 3'h1) begin
          op = byte_op_pkg::OP_CPSEQ;
        end else if (sub3 == 3'h2) begin
          op = byte_op_pkg::OP_CPSGT;
        end else if (sub3 == 3'h0) begin
          op = byte_op_pkg::OP_CPSLT;
        end else begin
          op = byte_op_pkg::OP_BYTE_OTHER;
        end
      end
      4'h7, 4'h8, 4'h9, 4'ha, 4'hb: op = byte_op_pkg::OP_BIT;
      4'hc: op = byte_op_pkg::OP_MOVE_FF;
      4'hd: op = instrWord[11] ? byte_op_pkg::OP_CONTROL : byte_op_pkg::OP_BRANCH;
      4'he: begin
        if (!instrWord[11]) begin
          op = byte_op_pkg::OP_BRANCH_COND;
        end else if (instrWord[10:9] == 2'h2 || instrWord[10:8] == 3'h7) begin
          op = byte_op_pkg::OP_CALLGOTO;
        end
      end
      4'hf: op = byte_op_pkg::OP_NOP;
    endcase
  end

  // ========================================================================
  // Operand selection and arithmetic.
  wire logic hasDest = (prefix >= 4'h1 && prefix <= 4'h5) || (prefix == 4'h0 && sub2 == 2'h1);
  wire logic isByteOp = hasDest || prefix == 4'h6 || op == byte_op_pkg::OP_MUL;
  wire logic usePins = fileIsPort && hasDest && destBit == `BOP_DEST_FILE;
  wire logic [7:0] fOp = usePins ? pinLevels : fileValue;
  wire logic [7:0] wOp = workingRegister;
  wire logic cIn = statusIn[`BOP_FLAG_C];
  wire logic isAddC = (op == byte_op_pkg::OP_ADDC);
  wire logic isSubW = (op == byte_op_pkg::OP_SUB) || (op == byte_op_pkg::OP_SUBB);
  wire logic isSubF = (op == byte_op_pkg::OP_SUBFB);
  wire logic [7:0] addX = isSubF ? wOp : fOp;
  wire logic [7:0] addY = isSubW ? ~wOp : (isSubF ? ~fOp : wOp);
  wire logic addCin = (op == byte_op_pkg::OP_SUB) ? 1'b1 : ((isAddC || isSubW || isSubF) && cIn);
  wire logic [8:0] sum = {1'b0, addX} + {1'b0, addY} + {8'h00, addCin};
  wire logic [4:0] nibSum = {1'b0, addX[3:0]} + {1'b0, addY[3:0]} + {4'h0, addCin};
  wire logic sumOv = (addX[7] == addY[7]) && (sum[7] != addX[7]);
  wire logic [7:0] decVal = fOp - 8'h01;
  wire logic [7:0] incVal = fOp + 8'h01;
  wire logic [15:0] product = wOp * fOp;

  // ========================================================================
  // Result, flags and skip per operation.
  logic [7:0] result;
  logic [4:0] flagMask;
  logic carryOut;
  logic skip;
  logic pcChange;
  always_comb begin
    result = 8'h00;
    flagMask = 5'h00;
    carryOut = 1'b0;
    skip = 1'b0;
    pcChange = 1'b0;
    unique case (op)
      byte_op_pkg::OP_ADD, byte_op_pkg::OP_ADDC: begin
        result = sum[7:0];
        flagMask = 5'h1f;
        carryOut = sum[8];
      end
      byte_op_pkg::OP_SUB, byte_op_pkg::OP_SUBB, byte_op_pkg::OP_SUBFB: begin
        result = sum[7:0];
        flagMask = 5'h1f;
        carryOut = sum[8];
      end
      byte_op_pkg::OP_AND: begin
        result = wOp & fOp;
        flagMask = 5'h14;
      end
      byte_op_pkg::OP_IOR: begin
        result = wOp | fOp;
        flagMask = 5'h14;
      end
      byte_op_pkg::OP_XOR: begin
        result = wOp ^ fOp;
        flagMask = 5'h14;
      end
      byte_op_pkg::OP_COM: begin
        result = ~fOp;
        flagMask = 5'h14;
      end
      byte_op_pkg::OP_CPSEQ: skip = (fOp == wOp);
      byte_op_pkg::OP_CPSGT: skip = (fOp > wOp);
      byte_op_pkg::OP_CPSLT: skip = (fOp < wOp);
      byte_op_pkg::OP_DECSZ: begin
        result = decVal;
        skip = (decVal == 8'h00);
      end
      byte_op_pkg::OP_DECSNZ: begin
        result = decVal;
        skip = (decVal != 8'h00);
      end
      byte_op_pkg::OP_INCSZ: begin
        result = incVal;
        skip = (incVal == 8'h00);
      end
      byte_op_pkg::OP_INCSNZ: begin
        result = incVal;
        skip = (incVal != 8'h00);
      end
      byte_op_pkg::OP_RLC: begin
        result = {fOp[6:0], cIn};
        flagMask = 5'h15;
        carryOut = fOp[7];
      end
      byte_op_pkg::OP_RRC: begin
        result = {cIn, fOp[7:1]};
        flagMask = 5'h15;
        carryOut = fOp[0];
      end
      byte_op_pkg::OP_RLN: begin
        result = {fOp[6:0], fOp[7]};
        flagMask = 5'h14;
      end
      byte_op_pkg::OP_RRN: begin
        result = {fOp[0], fOp[7:1]};
        flagMask = 5'h14;
      end
      byte_op_pkg::OP_MUL: result = product[7:0];
      byte_op_pkg::OP_BRANCH, byte_op_pkg::OP_CALLGOTO: pcChange = 1'b1;
      byte_op_pkg::OP_BRANCH_COND: begin
        unique case (instrWord[10:9])
          2'h0: pcChange = statusIn[`BOP_FLAG_Z] ^ instrWord[8];
          2'h1: pcChange = statusIn[`BOP_FLAG_C] ^ instrWord[8];
          2'h2: pcChange = statusIn[`BOP_FLAG_OV] ^ instrWord[8];
          2'h3: pcChange = statusIn[`BOP_FLAG_N] ^ instrWord[8];
        endcase
      end
      byte_op_pkg::OP_CONTROL: pcChange = (prefix == 4'hd);
      default: result = 8'h00;
    endcase
  end

  wire logic [4:0] flagValue = {result[7] & flagMask[`BOP_FLAG_N],
                                sumOv & flagMask[`BOP_FLAG_OV],
                                (result == 8'h00) & flagMask[`BOP_FLAG_Z],
                                nibSum[4] & flagMask[`BOP_FLAG_DC],
                                carryOut & flagMask[`BOP_FLAG_C]};
  wire logic [1:0] skipCycles = skip ? (isTwoWord(nextWord) ? 2'h3 : 2'h2) : 2'h1;
  wire logic [1:0] cycles = pcChange ? 2'h2 : skipCycles;
  wire logic presClear = fileIsTimerZero && prescaleAssigned_q &&
                         (op == byte_op_pkg::OP_BIT || (isByteOp && (!hasDest || destBit)));

  // ========================================================================
  // Word sequencer and decoded word.
  always_comb begin
    seq_d = seq_q;
    dec_d = dec_q;
    dec_d.valid = 1'b0;
    if (instrValid && inSecond) begin
      seq_d = byte_op_pkg::ST_FIRST;
      dec_d = '0;
      dec_d.valid = 1'b1;
      dec_d.cycles = 2'h2;
      if (firstWord_q[15:12] == `BOP_PREFIX_MOVE_FF) begin
        dec_d.op = byte_op_pkg::OP_MOVE_FF;
        dec_d.fileAddr = firstWord_q[11:0];
        dec_d.destAddr = instrWord[11:0];
      end else if (firstWord_q[11:8] == 4'he) begin
        dec_d.op = byte_op_pkg::OP_CONTROL;
        dec_d.literal = instrWord[7:0];
      end else begin
        dec_d.op = byte_op_pkg::OP_CALLGOTO;
        dec_d.target = {instrWord[11:0], firstWord_q[7:0]};
      end
    end else if (instrValid && isTwoWord(instrWord)) begin
      seq_d = byte_op_pkg::ST_SECOND;
    end else if (instrValid) begin
      dec_d.valid = 1'b1;
      dec_d.op = op;
      dec_d.writeWork = hasDest && destBit == `BOP_DEST_WORK;
      dec_d.writeFile = hasDest && destBit == `BOP_DEST_FILE;
      dec_d.fileAddr = effAddr;
      dec_d.destAddr = effAddr;
      dec_d.bitSel = instrWord[11:9];
      dec_d.literal = instrWord[7:0];
      dec_d.branchOffset = (op == byte_op_pkg::OP_BRANCH) ? instrWord[10:0]
                                                           : {3'h0, instrWord[7:0]};
      dec_d.target = 20'h00000;
      dec_d.result = result;
      dec_d.flagMask = flagMask;
      dec_d.flagValue = flagValue;
      dec_d.skip = skip;
      dec_d.cycles = cycles;
      dec_d.usePins = usePins;
      dec_d.prescalerClear = presClear;
    end
  end

  wire logic badWord = instrValid && inSecond && instrWord[15:12] != `BOP_PREFIX_SECOND;
  wire logic mulNow = instrValid && !inSecond && !isTwoWord(instrWord) &&
                      op == byte_op_pkg::OP_MUL;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      seq_q <= byte_op_pkg::ST_FIRST;
      dec_q <= '0;
      firstWord_q <= 16'h0000;
      prodHigh_q <= 8'h00;
      prodLow_q <= 8'h00;
      badSecond_q <= 1'b0;
    end else begin
      seq_q <= seq_d;
      dec_q <= dec_d;
      if (instrValid && !inSecond) begin
        firstWord_q <= instrWord;
      end
      // Product into high and low bytes.
      if (mulNow) begin
        prodHigh_q <= product[15:8];
        prodLow_q <= product[7:0];
      end
      if (instrValid && inSecond) begin
        badSecond_q <= badWord;
      end
    end
  end

  assign decodeOut = dec_q;
  assign productHighByte = prodHigh_q;
  assign productLowByte = prodLow_q;

  // ========================================================================
  // AXI4-Lite register slave.
  logic awHeld_q, wHeld_q, bvalid_q, arready_q, rvalid_q;
  logic [11:0] awAddr_q, arAddr_q;
  logic [31:0] wData_q, rdata_q;
  logic [3:0] wStrb_q;
  logic [1:0] bresp_q, rresp_q;

  wire logic awTake = s_axi_awvalid && !awHeld_q && !bvalid_q;
  wire logic wTake = s_axi_wvalid && !wHeld_q && !bvalid_q;
  wire logic wrDo = awHeld_q && wHeld_q && !bvalid_q;
  wire logic wrCtrl = (awAddr_q[11:2] == `BOP_CTRL_OFFSET >> 2);
  wire logic wrMapped = wrCtrl || awAddr_q[11:2] == `BOP_STATUS_OFFSET >> 2 ||
                        awAddr_q[11:2] == `BOP_PRODUCT_OFFSET >> 2;
  wire logic arTake = s_axi_arvalid && arready_q;
  wire logic [31:0] statusWord = {16'h0000, badSecond_q, 3'h0, seq_q, dec_q.cycles,
                                  3'h0, dec_q.flagMask};
  wire logic [31:0] ctrlWord = {23'h000000, prescaleAssigned_q, 4'h0, bank_q};
  wire logic [9:0] rdIdx = s_axi_araddr[11:2];
  wire logic rdCtrl = (rdIdx == `BOP_CTRL_OFFSET >> 2);
  wire logic rdStatus = (rdIdx == `BOP_STATUS_OFFSET >> 2);
  wire logic rdProduct = (rdIdx == `BOP_PRODUCT_OFFSET >> 2);
  wire logic [31:0] rdValue = rdCtrl ? ctrlWord : rdStatus ? statusWord :
                              rdProduct ? {16'h0000, prodHigh_q, prodLow_q} : 32'h00000000;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      bvalid_q <= 1'b0;
      awAddr_q <= 12'h000;
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
      bresp_q <= `BOP_RESP_OKAY;
      bank_q <= `BOP_BANK_RESET;
      prescaleAssigned_q <= `BOP_PRESCALE_RESET;
    end else begin
      if (awTake) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (wTake) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (wrDo) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wrMapped ? `BOP_RESP_OKAY : `BOP_RESP_SLVERR;
        if (wrCtrl && wStrb_q[0]) begin
          bank_q <= wData_q[`BOP_CTRL_BANK_MSB:`BOP_CTRL_BANK_LSB];
        end
        if (wrCtrl && wStrb_q[1]) begin
          prescaleAssigned_q <= wData_q[`BOP_CTRL_PRESCALE_BIT];
        end
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `BOP_RESP_OKAY;
    end else if (arTake) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rdValue;
      rresp_q <= (rdCtrl || rdStatus || rdProduct) ? `BOP_RESP_OKAY : `BOP_RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign s_axi_awready = !awHeld_q && !bvalid_q;
  assign s_axi_wready = !wHeld_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

endmodule

`default_nettype wire

// ---- byte_op_map.svh ----
/*
  Offsets, field positions, reset values and fixed codes of the byte-oriented decoder.
  Assumes inclusion by bare name from the package; the design files take the macros from it.
*/
`ifndef BYTE_OP_MAP_SVH
`define BYTE_OP_MAP_SVH

// ==========================================================================
// Register offsets.
`define BOP_CTRL_OFFSET 12'h000
`define BOP_STATUS_OFFSET 12'h004
`define BOP_PRODUCT_OFFSET 12'h008

// ==========================================================================
// Control register fields and reset values.
`define BOP_CTRL_BANK_LSB 0
`define BOP_CTRL_BANK_MSB 3
`define BOP_CTRL_PRESCALE_BIT 8
`define BOP_BANK_RESET 4'h0
`define BOP_PRESCALE_RESET 1'h0

// ==========================================================================
// Access bank split and upper bank.
`define BOP_ACCESS_SPLIT 8'h60
`define BOP_ACCESS_HIGH_BANK 4'hf
`define BOP_ACCESS_LOW_BANK 4'h0

// ==========================================================================
// Status flag bit positions.
`define BOP_FLAG_C 0
`define BOP_FLAG_DC 1
`define BOP_FLAG_Z 2
`define BOP_FLAG_OV 3
`define BOP_FLAG_N 4

// ==========================================================================
// Instruction field codes.
`define BOP_PREFIX_MOVE_FF 4'hc
`define BOP_PREFIX_SECOND 4'hf
`define BOP_DEST_WORK 1'h0
`define BOP_DEST_FILE 1'h1
`define BOP_ACCESS_FORCED 1'h0

// ==========================================================================
// Bus responses.
`define BOP_RESP_OKAY 2'h0
`define BOP_RESP_SLVERR 2'h2

`endif

// ---- byte_op_pkg.sv ----
/*
  Types of the byte-oriented decoder: operation kinds, sequencer states, decoded word.
  Assumes byte_op_map.svh is on the include path.
*/
`include "byte_op_map.svh"

package byte_op_pkg;

  // ========================================================================
  // Operation kinds.
  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_ADD = 5'h01, OP_ADDC = 5'h02, OP_AND = 5'h03,
    OP_IOR = 5'h04, OP_XOR = 5'h05, OP_COM = 5'h06, OP_CPSEQ = 5'h07,
    OP_CPSGT = 5'h08, OP_CPSLT = 5'h09, OP_DECSZ = 5'h0a, OP_DECSNZ = 5'h0b,
    OP_INCSZ = 5'h0c, OP_INCSNZ = 5'h0d, OP_SUB = 5'h0e, OP_SUBB = 5'h0f,
    OP_SUBFB = 5'h10, OP_RLC = 5'h11, OP_RRC = 5'h12, OP_RLN = 5'h13,
    OP_RRN = 5'h14, OP_MUL = 5'h15, OP_MOVE_FF = 5'h16, OP_BYTE_OTHER = 5'h17,
    OP_BIT = 5'h18, OP_LITERAL = 5'h19, OP_CALLGOTO = 5'h1a, OP_BRANCH = 5'h1b,
    OP_BRANCH_COND = 5'h1c, OP_CONTROL = 5'h1d
  } op_e;

  // ========================================================================
  // Word sequencer states.
  typedef enum logic [1:0] {
    ST_FIRST = 2'b01,
    ST_SECOND = 2'b10
  } seq_e;

  // ========================================================================
  // Decoded instruction.
  typedef struct packed {
    logic valid;
    op_e op;
    logic writeWork;
    logic writeFile;
    logic [11:0] fileAddr;
    logic [11:0] destAddr;
    logic [2:0] bitSel;
    logic [7:0] literal;
    logic [10:0] branchOffset;
    logic [19:0] target;
    logic [7:0] result;
    logic [4:0] flagMask;
    logic [4:0] flagValue;
    logic skip;
    logic [1:0] cycles;
    logic usePins;
    logic prescalerClear;
  } decode_s;

endpackage

// ---- fetch_model.sv ----
/* Program fetch model: one word per request, presented one cycle later.
   Assumes requests arrive from the bench at the rising edge. */
`timescale 1ns/1ns
`default_nettype none
module fetch_model (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic go,
  input wire logic [15:0] word,
  input wire logic [15:0] follow,
  output logic instrValid,
  output logic [15:0] instrWord,
  output logic [15:0] nextWord
);
  // ======================================================================
  // Fetch register.
  // Idle words are inverted every cycle, so a stale word looks current again on every second idle cycle.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      instrValid <= 1'h0;
      instrWord <= 16'h0000;
      nextWord <= 16'h0000;
    end else begin
      instrValid <= go;
      instrWord <= go ? word : ~instrWord;
      nextWord <= go ? follow : ~nextWord;
    end
  end
endmodule
`default_nettype wire

// ---- tb.sv ----
/* Bench of the decoder with fetch model and bus master.
   Assumes package, fetch model and checker compiled first. */
`timescale 1ns/1ns
`default_nettype none
module tb;
  // ======================================================================
  // Stimulus and instances.
  logic clk_sys = 1'h0, rstn = 1'h0, go = 1'h0, fileIsPort = 1'h0, fileIsTimerZero = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0, instrValid, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [4:0] statusIn = 5'h00;
  logic [7:0] workingRegister = 8'h00, fileValue = 8'h00, pinLevels = 8'h00;
  logic [7:0] productHighByte, productLowByte;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [15:0] word = 16'h0000, follow = 16'h0000, instrWord, nextWord;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [23:0] tbl [23] = '{24'h241301, 24'h201302, 24'h5c130e, 24'h58130f, 24'h541310,
    24'h141303, 24'h101304, 24'h181305, 24'h1c1306, 24'h341311, 24'h301312, 24'h441313,
    24'h401314, 24'h621307, 24'h641308, 24'h601309, 24'h2c130a, 24'h4c130b, 24'h3c130c,
    24'h48130d, 24'h021315, 24'hd0051b, 24'he2031c};
  byte_op_pkg::decode_s decodeOut;
  int mismatches = 0, n_tests = 0;
  fetch_model fetch_model_inst (.*);
  byte_op_instruction_decoder byte_op_instruction_decoder_inst (.*);
  always #25 clk_sys = ~clk_sys;
  // ======================================================================
  // Shared tasks.
  task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task put(input logic [15:0] w, input logic [15:0] n);
    @(posedge clk_sys);
    go <= 1'h1;
    word <= w;
    follow <= n;
    @(posedge clk_sys);
    go <= 1'h0;
  endtask
  task run(input logic [15:0] w, input logic [15:0] n);
    put(w, n);
    do @(negedge clk_sys); while (decodeOut.valid !== 1'h1);
    @(posedge clk_sys);
  endtask
  task axw(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
    while (!s_axi_bvalid) @(posedge clk_sys);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task axr(input logic [11:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge clk_sys); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    while (!s_axi_rvalid) @(posedge clk_sys);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  // ======================================================================
  // Scenarios.
  task t_table;
    foreach (tbl[i]) begin
      run(tbl[i][23:8], 16'h0000);
      cmp("op", tbl[i][7:0], decodeOut.op);
    end
  endtask
  task t_add;
    workingRegister <= 8'h05;
    fileValue <= 8'h07;
    run(16'h2613, 16'h0000);
    cmp("file", 1, decodeOut.writeFile);
    cmp("addr", 12'h013, decodeOut.fileAddr);
    cmp("sum", 8'h0c, decodeOut.result);
    run(16'h2413, 16'h0000);
    cmp("work", 1, decodeOut.writeWork);
  endtask
  task t_move;
    put(16'hc123, 16'h0000);
    run(16'hf456, 16'h0000);
    cmp("src", 12'h123, decodeOut.fileAddr);
    cmp("dst", 12'h456, decodeOut.destAddr);
    cmp("mcyc", 2, decodeOut.cycles);
    run(16'hf000, 16'h0000);
    cmp("lone", 0, decodeOut.op);
  endtask
  task t_skip;
    fileValue <= 8'h01;
    run(16'h2e13, 16'hc000);
    cmp("skip", 1, decodeOut.skip);
    cmp("cyc3", 3, decodeOut.cycles);
    run(16'h2e13, 16'h0000);
    cmp("cyc2", 2, decodeOut.cycles);
    fileValue <= 8'h05;
    run(16'h2e13, 16'h0000);
    cmp("cyc1", 1, decodeOut.cycles);
  endtask
  task t_mul;
    workingRegister <= 8'h20;
    fileValue <= 8'h10;
    run(16'h0213, 16'h0000);
    cmp("prod", 16'h0200, {productHighByte, productLowByte});
  endtask
  task t_port;
    fileIsPort <= 1'h1;
    pinLevels <= 8'h0f;
    fileValue <= 8'hff;
    workingRegister <= 8'h01;
    run(16'h2613, 16'h0000);
    cmp("pins", 1, decodeOut.usePins);
    cmp("pres", 8'h10, decodeOut.result);
    cmp("dc", 5'h02, decodeOut.flagValue);
    fileIsPort <= 1'h0;
  endtask
  task t_regs;
    axw(12'h000, 32'h00000103);
    cmp("wr", 0, rsp);
    axr(12'h000);
    cmp("ctrl", 32'h103, rd);
    axr(12'hffc);
    cmp("bad", 2, rsp);
    fileIsTimerZero <= 1'h1;
    run(16'h2713, 16'h0000);
    cmp("bank", 12'h313, decodeOut.fileAddr);
    cmp("clr", 1, decodeOut.prescalerClear);
    run(16'h2493, 16'h0000);
    cmp("acc", 12'hf93, decodeOut.fileAddr);
    cmp("keep", 0, decodeOut.prescalerClear);
  endtask
  task t_misc;
    put(16'hec34, 16'h0000);
    run(16'hf567, 16'h0000);
    cmp("tgt", 20'h56734, decodeOut.target);
    run(16'h7a13, 16'h0000);
    cmp("bit", 5, decodeOut.bitSel);
    run(16'h0f55, 16'h0000);
    cmp("lit", 8'h55, decodeOut.literal);
    run(16'he2a5, 16'h0000);
    cmp("boff", 11'h0a5, decodeOut.branchOffset);
  endtask
  // ======================================================================
  // Sequence, watchdog and verdict.
  task complete_run;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    rstn <= 1'h1;
    t_table;
    t_add;
    t_move;
    t_skip;
    t_mul;
    t_port;
    t_regs;
    t_misc;
    complete_run;
  end
  initial begin
    #100000;
    mismatches++;
    complete_run;
  end
endmodule
`default_nettype wire
